// File: serdes_word_defs.vh
// constants for the parallel word mapper of a serializer/deserializer
// assumes inclusion by bare name from the mapper and its fifo
`ifndef SERDES_WORD_DEFS_VH
`define SERDES_WORD_DEFS_VH

// parallel bus geometry
`define WORD_W         20
`define HALF_W         10
`define LOW_BYTE_LSB   0
`define HIGH_BYTE_LSB  8
`define HIGH_SYM_LSB   10
`define LOW_K_BIT      16
`define HIGH_K_BIT     17
`define SPARE_LO_BIT   18
`define SPARE_HI_BIT   19

// receive output enables (active low, one per bit)
`define OE_N_ALL_OFF   20'hFFFFF
`define OE_N_ALL_ON    20'h00000
`define OE_N_DECODED   20'hC0000

// reset values of the strapped inputs: rate pins pulled up, codec on
`define RATE_RESET     1'b1
`define CODE_RESET     1'b1
`define DISP_RESET     1'b0

// line coding special codes
`define K28_X          5'h1C
`define K28_SIX        6'h0F
`define ALT_FOUR       4'h7

// transmit buffering
`define FIFO_DEPTH     16
`define FIFO_ADDR_W    4

`endif

// File: word_fifo.v
// word fifo with a registered head word, valid/ready on both sides
// assumes depth is a power of two; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "serdes_word_defs.vh"

module word_fifo #(
    parameter WIDTH  = 21,
    parameter DEPTH  = `FIFO_DEPTH,
    parameter ADDR_W = `FIFO_ADDR_W
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // filling side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // draining side
    output reg  [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);

localparam [ADDR_W:0] FULL_COUNT = DEPTH;

reg  [WIDTH-1:0] mem [0:DEPTH-1];
reg  [ADDR_W-1:0] wr_ptr;
reg  [ADDR_W-1:0] rd_ptr;
reg  [ADDR_W:0]   count;
wire              push;
wire              pop;

assign in_ready = (count != FULL_COUNT);
assign push     = in_valid && in_ready;
assign pop      = (count != {(ADDR_W+1){1'b0}}) && (!out_valid || out_ready);

////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (push) begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge clk) begin
    if (reset) begin
        wr_ptr    <= {ADDR_W{1'b0}};
        rd_ptr    <= {ADDR_W{1'b0}};
        count     <= {(ADDR_W+1){1'b0}};
        out_data  <= {WIDTH{1'b0}};
        out_valid <= 1'b0;
    end else begin
        if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
            out_data  <= mem[rd_ptr];
            out_valid <= 1'b1;
            rd_ptr    <= rd_ptr + 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
        case ({push, pop})
            2'b10: count <= count + 1'b1;
            2'b01: count <= count - 1'b1;
            default: count <= count;
        endcase
    end
end

endmodule

`default_nettype wire

// File: serdes_parallel_word_mapper.v
// parallel side of a serializer/deserializer: transmit word capture,
// 8b/10b mapping, bit-serial transmit and receive, receive word output
// assumes one clock for parallel and serial sides, one bit per cycle
//
// Overview of operation
// - capture transmit word every accepted rising edge
// - full rate sends all twenty bits, unchanged when coding is off
// - half rate sends only lower ten bits
// - bytes 0-7/8-15 with K flags 16/17
// - transmit bits 18 and 19 ignored when coding
// - coding: two bytes full rate, one half
// - low byte first, least significant bit first
// - receive words valid at recovered clock rise
// - receive outputs high impedance during reset
// - full rate twenty bits valid, half ten
// - decode bypassed presents raw received symbols
// - decoded bytes on 0-15, K on 16/17
// - receive bits 18,19 undriven while decoding
// - decoding: two bytes full rate, one half
// - first received byte and bit lowest
// - recovered clock is bit rate over 10/20
// - recovered clock low throughout reset
// - transmit rate pin selects twenty or ten
// - receive rate pin high selects twenty
// - half rate decode: eight bits plus status
`timescale 1ns/1ps
`default_nettype none
`include "serdes_word_defs.vh"

module serdes_parallel_word_mapper #(
    parameter FIFO_DEPTH  = `FIFO_DEPTH,
    parameter FIFO_ADDR_W = `FIFO_ADDR_W
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // transmit parallel word
    input  wire [19:0] tx_data,
    input  wire        tx_valid,
    output wire        tx_ready,
    // strapped configuration pins
    input  wire        tx_rate_select,
    input  wire        rx_rate_select,
    input  wire        code_enable,
    // serial transmit line
    output reg         serial_out_pos,
    output reg         serial_out_neg,
    output reg         serial_out_oe_n,
    // serial receive line
    input  wire        serial_in_pos,
    input  wire        serial_in_neg,
    // receive parallel word
    output reg  [19:0] rx_data,
    output reg  [19:0] rx_data_oe_n,
    output reg         rx_clk
);

// 6b codes for RD-, abcdei with a as msb, entry 31 first
localparam [191:0] CODE6 = {
    6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27
};
// 4b codes for RD-, fghj with f as msb, entry 7 first
localparam [31:0] CODE4 = {
    4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB
};
localparam FIFO_W = `WORD_W + 1;

////////////////////////////////////////////////////////////////////////////
// coding functions

function [2:0] ones6;
    input [5:0] v;
    integer i;
    begin
        ones6 = 3'h0;
        for (i = 0; i < 6; i = i + 1) begin
            ones6 = ones6 + {2'b00, v[i]};
        end
    end
endfunction

function [9:0] bitrev10;
    input [9:0] v;
    integer i;
    begin
        for (i = 0; i < 10; i = i + 1) begin
            bitrev10[i] = v[9-i];
        end
    end
endfunction

// returns {disparity after, 10b symbol with bit a in position 0}
function [10:0] encode_byte;
    input       k;
    input [7:0] d;
    input       rd;
    reg   [5:0] six;
    reg   [3:0] four;
    reg         rd1;
    reg         k28;
    begin
        k28  = k && (d[4:0] == `K28_X);
        six  = k28 ? `K28_SIX : CODE6[d[4:0]*6 +: 6];
        if (rd && (ones6(six) != 3'h3 || d[4:0] == 5'h07)) begin
            six = ~six;
        end
        rd1  = (ones6(six) != 3'h3) ? ~rd : rd;
        four = CODE4[d[7:5]*4 +: 4];
        if (k28 && !rd1 && (d[7:5] == 3'h1 || d[7:5] == 3'h2 ||
                            d[7:5] == 3'h5 || d[7:5] == 3'h6)) begin
            four = ~four;
        end
        if (d[7:5] == 3'h7 && (k || (!rd1 && six[1:0] == 2'b11) ||
                               (rd1 && six[1:0] == 2'b00))) begin
            four = `ALT_FOUR;
        end
        if (rd1 && (ones6({2'b00, four}) != 3'h2 || d[7:5] == 3'h3)) begin
            four = ~four;
        end
        encode_byte = {(ones6({2'b00, four}) != 3'h2) ? ~rd1 : rd1,
                       bitrev10({six, four})};
    end
endfunction

// returns {K status, byte} for a symbol with bit a in position 0
function [8:0] decode_symbol;
    input [9:0] sym;
    reg   [9:0] cat;
    reg   [5:0] t6;
    reg   [3:0] t4;
    reg   [3:0] f;
    reg   [4:0] x;
    reg   [2:0] y;
    reg         k28;
    reg         alt;
    integer     i;
    begin
        cat = bitrev10(sym);
        x   = 5'h00;
        y   = 3'h0;
        k28 = (cat[9:4] == `K28_SIX) || (cat[9:4] == ~`K28_SIX);
        for (i = 0; i < 32; i = i + 1) begin
            t6 = CODE6[i*6 +: 6];
            if (cat[9:4] == t6 || ((ones6(t6) != 3'h3 || i == 7) &&
                                    cat[9:4] == ~t6)) begin
                x = i[4:0];
            end
        end
        if (k28) begin
            x = `K28_X;
        end
        f = cat[3:0];
        if (cat[9:4] == ~`K28_SIX && ones6({2'b00, f}) == 3'h2 &&
            f != 4'hC && f != 4'h3) begin
            f = ~f;
        end
        alt = (f == `ALT_FOUR) || (f == ~`ALT_FOUR);
        for (i = 0; i < 8; i = i + 1) begin
            t4 = CODE4[i*4 +: 4];
            if (f == t4 || ((ones6({2'b00, t4}) != 3'h2 || i == 3) &&
                            f == ~t4)) begin
                y = i[2:0];
            end
        end
        if (alt) begin
            y = 3'h7;
        end
        decode_symbol = {k28 || (alt && (x == 5'h17 || x == 5'h1B ||
                                         x == 5'h1D || x == 5'h1E)),
                         y, x};
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers: rates, codec enable and serial inputs

wire [4:0] pin_raw;
wire [4:0] pin_sync;
wire [4:0] pin_reset;
wire       tx_full_rate;
wire       rx_full_rate;
wire       code_on;
wire       line_bit;
wire       line_active;

assign pin_raw   = {serial_in_neg, serial_in_pos, code_enable,
                    rx_rate_select, tx_rate_select};
assign pin_reset = {1'b0, 1'b0, `CODE_RESET, `RATE_RESET, `RATE_RESET};

genvar g;
generate
    for (g = 0; g < 5; g = g + 1) begin : pin_sync_gen
        reg meta;
        reg sync;
        always @(posedge clk) begin
            if (reset) begin
                meta <= pin_reset[g];
                sync <= pin_reset[g];
            end else begin
                meta <= pin_raw[g];
                sync <= meta;
            end
        end
        assign pin_sync[g] = sync;
    end
endgenerate

assign tx_full_rate = pin_sync[0];
assign rx_full_rate = pin_sync[1];
assign code_on      = pin_sync[2];
assign line_bit     = pin_sync[3];
assign line_active  = pin_sync[3] ^ pin_sync[4];

////////////////////////////////////////////////////////////////////////////
// transmit capture and mapping

reg  [19:0]       cap_word;
reg               cap_valid;
reg               cap_full;
reg               cap_code;
reg               tx_disp;
wire [10:0]       enc_lo;
wire [10:0]       enc_hi;
reg  [19:0]       tx_payload;
wire              fifo_in_ready;
wire [FIFO_W-1:0] fifo_out_data;
wire              fifo_out_valid;
wire              fifo_out_ready;
wire              capture;

assign tx_ready = !cap_valid || fifo_in_ready;
assign capture  = tx_valid && tx_ready;

// bits 18 and 19 never reach the encoder
assign enc_lo = encode_byte(cap_word[`LOW_K_BIT],
                            cap_word[7:0], tx_disp);
assign enc_hi = encode_byte(cap_word[`HIGH_K_BIT],
                            cap_word[15:8], enc_lo[10]);

always @* begin
    if (cap_code && cap_full) begin
        tx_payload = {enc_hi[9:0], enc_lo[9:0]};
    end else if (cap_code) begin
        tx_payload = {10'h000, enc_lo[9:0]};
    end else if (cap_full) begin
        tx_payload = cap_word;
    end else begin
        tx_payload = {10'h000, cap_word[9:0]};
    end
end

always @(posedge clk) begin
    if (reset) begin
        cap_word  <= 20'h00000;
        cap_valid <= 1'b0;
        cap_full  <= `RATE_RESET;
        cap_code  <= `CODE_RESET;
        tx_disp   <= `DISP_RESET;
    end else begin
        if (capture) begin
            cap_word  <= tx_data;
            cap_full  <= tx_full_rate;
            cap_code  <= code_on;
            cap_valid <= 1'b1;
        end else if (fifo_in_ready) begin
            cap_valid <= 1'b0;
        end
        if (cap_valid && fifo_in_ready && cap_code) begin
            tx_disp <= cap_full ? enc_hi[10] : enc_lo[10];
        end
    end
end

word_fifo #(
    .WIDTH  (FIFO_W),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (FIFO_ADDR_W)
) tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   ({cap_full, tx_payload}),
    .in_valid  (cap_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
);

////////////////////////////////////////////////////////////////////////////
// serializer: one bit per clock, bit 0 of the word first

reg [19:0] ser_word;
reg [4:0]  ser_left;

assign fifo_out_ready = (ser_left == 5'd0);

always @(posedge clk) begin
    if (reset) begin
        ser_word        <= 20'h00000;
        ser_left        <= 5'd0;
        serial_out_pos  <= 1'b0;
        serial_out_neg  <= 1'b1;
        serial_out_oe_n <= 1'b1;
    end else begin
        serial_out_oe_n <= 1'b0;
        if (ser_left == 5'd0 && fifo_out_valid) begin
            serial_out_pos <= fifo_out_data[0];
            serial_out_neg <= ~fifo_out_data[0];
            ser_word       <= {1'b0, fifo_out_data[19:1]};
            ser_left       <= fifo_out_data[`WORD_W] ? 5'd19 : 5'd9;
        end else if (ser_left != 5'd0) begin
            serial_out_pos <= ser_word[0];
            serial_out_neg <= ~ser_word[0];
            ser_word       <= {1'b0, ser_word[19:1]};
            ser_left       <= ser_left - 5'd1;
        end else begin
            serial_out_pos <= 1'b0;
            serial_out_neg <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// deserializer and receive word output

reg  [19:0] rx_acc;
reg  [19:0] next_word;
reg  [4:0]  rx_count;
wire [4:0]  rx_last;
wire [4:0]  rx_mid;
wire [8:0]  dec_lo;
wire [8:0]  dec_hi;

assign rx_last = rx_full_rate ? 5'd19 : 5'd9;
assign rx_mid  = rx_full_rate ? 5'd9 : 5'd4;

always @* begin
    next_word           = rx_acc;
    next_word[rx_count] = line_bit;
end

assign dec_lo = decode_symbol(next_word[9:0]);
assign dec_hi = decode_symbol(next_word[19:10]);

always @(posedge clk) begin
    if (reset) begin
        rx_acc       <= 20'h00000;
        rx_count     <= 5'd0;
        rx_clk       <= 1'b0;
        rx_data      <= 20'h00000;
        rx_data_oe_n <= `OE_N_ALL_OFF;
    end else if (line_active) begin
        rx_acc <= next_word;
        if (rx_count >= rx_last) begin
            rx_count <= 5'd0;
            rx_clk   <= 1'b0;
            if (!code_on && rx_full_rate) begin
                rx_data      <= next_word;
                rx_data_oe_n <= `OE_N_ALL_ON;
            end else if (!code_on) begin
                rx_data      <= {10'h000, next_word[9:0]};
                rx_data_oe_n <= `OE_N_ALL_ON;
            end else if (rx_full_rate) begin
                rx_data      <= {2'b00, dec_hi[8], dec_lo[8],
                                 dec_hi[7:0], dec_lo[7:0]};
                rx_data_oe_n <= `OE_N_DECODED;
            end else begin
                rx_data      <= {3'h0, dec_lo[8], 8'h00,
                                 dec_lo[7:0]};
                rx_data_oe_n <= `OE_N_DECODED;
            end
        end else begin
            rx_count <= rx_count + 5'd1;
            if (rx_count == rx_mid) begin
                rx_clk <= 1'b1;
            end
        end
    end
end

endmodule

`default_nettype wire

// File: serdes_word_mapper_props.sv
// concurrent checks on the receive side of the parallel word mapper
// assumes one clock, synchronous active-high reset, two-flop input sync
`timescale 1ns/1ps
`default_nettype none

module serdes_word_mapper_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // pins and serial input
    input wire logic        rx_rate_select,
    input wire logic        code_enable,
    input wire logic        serial_in_pos,
    input wire logic        serial_in_neg,
    // receive word
    input wire logic [19:0] rx_data,
    input wire logic [19:0] rx_data_oe_n,
    input wire logic        rx_clk
);
    logic       bit_q1;
    logic       bit_q2;
    logic [4:0] word_pos;
    logic [4:0] word_len;

    default clocking cb @(posedge clk); endclocking

    assign word_len = rx_rate_select ? 5'd20 : 5'd10;

    // mirrors the input synchroniser: a line bit counts two edges late
    always @(posedge clk) begin
        if (reset) begin
            bit_q1 <= 1'b0;
            bit_q2 <= 1'b0;
            word_pos <= 5'd0;
        end else begin
            bit_q1 <= serial_in_pos ^ serial_in_neg;
            bit_q2 <= bit_q1;
            if (bit_q2)
                word_pos <= (word_pos == word_len - 5'd1) ? 5'd0
                                                          : word_pos + 5'd1;
        end
    end

    ////////////////////////////////////////
    a_rx_float_reset:
    assert property (disable iff (1'b0) reset |=> rx_data_oe_n == 20'hFFFFF)
        else $error("receive bus driven in reset");
    a_rx_clk_reset:
    assert property (disable iff (1'b0) reset |=> !rx_clk)
        else $error("recovered clock high in reset");
    a_word_at_fall:
    assert property (disable iff (reset)
        !$past(reset) && $changed(rx_data) |-> $fell(rx_clk))
        else $error("receive word changed away from clock fall");
    a_steady_while_high:
    assert property (disable iff (reset)
        rx_clk |-> $stable(rx_data) && $stable(rx_data_oe_n))
        else $error("receive word moved while clock high");
    a_fall_word_end:
    assert property (disable iff (reset) $fell(rx_clk) |-> word_pos == 5'd0)
        else $error("recovered clock fell off a word boundary");
    a_rise_mid_word:
    assert property (disable iff (reset)
        $rose(rx_clk) |-> word_pos == (word_len >> 1))
        else $error("recovered clock rose off mid word");
    a_clk_on_bit:
    assert property (disable iff (reset) $changed(rx_clk) |-> $past(bit_q2))
        else $error("recovered clock moved without a line bit");
    a_decode_top_float:
    assert property (disable iff (reset)
        $fell(rx_clk) && $past(code_enable, 3) && rx_rate_select
        |-> rx_data_oe_n == 20'hC0000)
        else $error("decoded word enables wrong");
    a_raw_low_driven:
    assert property (disable iff (reset)
        $fell(rx_clk) && !$past(code_enable, 3)
        |-> rx_data_oe_n[9:0] == 10'h000)
        else $error("raw word low half not driven");
endmodule

bind serdes_parallel_word_mapper serdes_word_mapper_props props (
    .clk(clk), .reset(reset), .rx_rate_select(rx_rate_select),
    .code_enable(code_enable), .serial_in_pos(serial_in_pos),
    .serial_in_neg(serial_in_neg), .rx_data(rx_data),
    .rx_data_oe_n(rx_data_oe_n), .rx_clk(rx_clk)
);
`default_nettype wire

// File: serial_source.sv
// far end of the receive line: sends bits first bit lowest
// assumes bits launch at the falling edge of the shared clock
`timescale 1ns/1ps
`default_nettype none

module serial_source (
    // clock
    input  wire logic clk,
    // serial line
    output var  logic pos,
    output var  logic neg
);
    logic last;

    initial begin
        pos = 1'b0;
        neg = 1'b0;
        last = 1'b0;
    end

    // equal legs carry no bit; slow leaves a gap after every bit
    task automatic send(input logic [19:0] w, input int nb, input bit slow);
        int i;
        for (i = 0; i < nb; i++) begin
            @(negedge clk);
            pos = w[i];
            neg = ~w[i];
            last = w[i];
            if (slow) begin
                @(negedge clk);
                pos = ~last;
                neg = ~last;
            end
        end
        @(negedge clk);
        pos = ~last;
        neg = ~last;
    endtask
endmodule
`default_nettype wire

// File: test_serdes_parallel_word_mapper.sv
// self-checking bench for the parallel word mapper
// assumes mapper, fifo, checker and serial_source are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_serdes_parallel_word_mapper;
    logic        clk;
    logic        reset;
    logic [19:0] tx_data;
    logic        tx_valid;
    logic        tx_rate_select;
    logic        rx_rate_select;
    logic        code_enable;
    wire         tx_ready;
    wire         serial_out_pos;
    wire         serial_out_neg;
    wire         serial_out_oe_n;
    wire         serial_in_pos;
    wire         serial_in_neg;
    wire  [19:0] rx_data;
    wire  [19:0] rx_data_oe_n;
    wire         rx_clk;
    int          n_mismatch;
    int          comparisons;
    logic [19:0] txq[$];
    logic [19:0] expq[$];

    serdes_parallel_word_mapper dut (
        .clk(clk), .reset(reset), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_rate_select(tx_rate_select),
        .rx_rate_select(rx_rate_select), .code_enable(code_enable),
        .serial_out_pos(serial_out_pos), .serial_out_neg(serial_out_neg),
        .serial_out_oe_n(serial_out_oe_n), .serial_in_pos(serial_in_pos),
        .serial_in_neg(serial_in_neg), .rx_data(rx_data),
        .rx_data_oe_n(rx_data_oe_n), .rx_clk(rx_clk)
    );

    serial_source src (.clk(clk), .pos(serial_in_pos), .neg(serial_in_neg));

    always #50 clk = ~clk;

    ////////////////////////////////////////
    task automatic check(input string what, input logic [19:0] e,
                         input logic [19:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic set_pins(input logic tr, input logic rr, input logic ce);
        @(negedge clk);
        tx_rate_select = tr;
        rx_rate_select = rr;
        code_enable = ce;
        repeat (3) @(negedge clk);
    endtask

    task automatic sc_reset(input int n);
        @(negedge clk);
        reset = 1'b1;
        repeat (n) @(negedge clk);
        check("rx enables in reset", 20'hFFFFF, rx_data_oe_n);
        check("rx clock in reset", 20'h0, {19'h0, rx_clk});
        check("tx line in reset", 20'h1, {19'h0, serial_out_oe_n});
        reset = 1'b0;
    endtask

    task automatic q(input logic [19:0] w, input logic [19:0] e);
        txq.push_back(w);
        expq.push_back(e);
    endtask

    // offers the queued words back to back and reads the line as it goes
    task automatic tx_run(input int wl, output int stalls);
        int i;
        int k;
        int b;
        int guard;
        logic [19:0] got;
        logic [19:0] m;
        m = (wl == 20) ? 20'hFFFFF : 20'h003FF;
        stalls = 0;
        fork
            begin
                i = 0;
                guard = 0;
                while (i < txq.size() && guard < 2000) begin
                    tx_data = txq[i];
                    tx_valid = 1'b1;
                    if (tx_ready === 1'b1) i++;
                    else stalls++;
                    guard++;
                    @(negedge clk);
                end
                tx_valid = 1'b0;
                if (guard >= 2000) check("tx accept bound", 20'h1, 20'h0);
            end
            begin
                repeat (4) @(negedge clk);
                for (k = 0; k < expq.size(); k++) begin
                    got = 20'h0;
                    for (b = 0; b < wl; b++) begin
                        got[b] = serial_out_pos;
                        check("tx legs", 20'h1, {18'h0, serial_out_oe_n,
                              serial_out_pos ^ serial_out_neg});
                        @(negedge clk);
                    end
                    check("tx word", expq[k] & m, got & m);
                end
            end
        join
        txq.delete();
        expq.delete();
    endtask

    task automatic rx_word(input logic [19:0] w, input int nb, input bit slow,
                           input logic [19:0] dm, input logic [19:0] e,
                           input logic [19:0] om, input logic [19:0] eoe);
        int g;
        src.send(w, nb, slow);
        g = 0;
        while (rx_clk !== 1'b0 && g < 8) begin
            @(negedge clk);
            g++;
        end
        if (g >= 8) check("rx word bound", 20'h1, 20'h0);
        check("rx data", e, rx_data & dm);
        check("rx enables", eoe, rx_data_oe_n & om);
    endtask

    ////////////////////////////////////////
    task automatic sc_tx_raw();
        int st;
        set_pins(1'b1, 1'b1, 1'b0);
        q(20'h5A3C1, 20'h5A3C1);
        q(20'hFFFFF, 20'hFFFFF);
        q(20'h00001, 20'h00001);
        tx_run(20, st);
    endtask

    // serializer drains slower than words are offered, so the fifo fills
    task automatic sc_tx_fill();
        int st;
        int i;
        set_pins(1'b0, 1'b1, 1'b0);
        for (i = 0; i < 24; i++) q(20'hABC00 | 20'(i * 37), 20'(i * 37));
        tx_run(10, st);
        check("fifo refused", 20'h1, {19'h0, st > 0});
    endtask

    task automatic sc_rx_raw();
        set_pins(1'b1, 1'b1, 1'b0);
        rx_word(20'hA53C6, 20, 1'b0, 20'hFFFFF, 20'hA53C6, 20'hFFFFF,
                20'h0);
        set_pins(1'b1, 1'b0, 1'b0);
        rx_word(20'h002D1, 10, 1'b1, 20'h003FF, 20'h002D1, 20'h003FF,
                20'h0);
    endtask

    // reset mid word, then coded words from a fresh negative disparity
    task automatic sc_tx_coded();
        int st;
        src.send(20'h00000, 15, 1'b0);
        sc_reset(3);
        set_pins(1'b1, 1'b1, 1'b1);
        q(20'hDB5BC, 20'h5557C);
        q(20'hDB5BC, 20'h55683);
        tx_run(20, st);
        set_pins(1'b0, 1'b1, 1'b1);
        q(20'hDB5BC, 20'h0017C);
        tx_run(10, st);
    endtask

    task automatic sc_rx_coded();
        set_pins(1'b1, 1'b1, 1'b1);
        rx_word(20'h5557C, 20, 1'b0, 20'h3FFFF, 20'h1B5BC, 20'hFFFFF,
                20'hC0000);
        set_pins(1'b1, 1'b0, 1'b1);
        rx_word(20'h00283, 10, 1'b1, 20'h100FF, 20'h100BC, 20'h100FF,
                20'h0);
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        tx_data = 20'h0;
        tx_valid = 1'b0;
        tx_rate_select = 1'b1;
        rx_rate_select = 1'b1;
        code_enable = 1'b1;
        n_mismatch = 0;
        comparisons = 0;
        sc_reset(16);
        sc_tx_raw();
        sc_tx_fill();
        sc_rx_raw();
        sc_tx_coded();
        sc_rx_coded();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        check("run bound", 20'h1, 20'h0);
        complete_run();
    end
endmodule
`default_nettype wire
